// ### src/seebs_defines.svh
// Constants of the serial EEPROM bus slave: select byte layout,
// memory geometry and write cycle timing.
// Assumes a 100 MHz system clock.
`ifndef SEEBS_DEFINES_SVH
`define SEEBS_DEFINES_SVH

`define SEEBS_TYPE_ID        4'hA
`define SEEBS_TYPE_MSB       7
`define SEEBS_TYPE_LSB       4
`define SEEBS_RW_BIT         0
`define SEEBS_ADDR_W         11
`define SEEBS_ROW_BITS       4
`define SEEBS_CLK_NS         10
`define SEEBS_WRITE_CYCLE_NS 5000000
`define SEEBS_WRITE_CYCLES   (`SEEBS_WRITE_CYCLE_NS / `SEEBS_CLK_NS)
`define SEEBS_BIT_ACK        4'h8
`define SEEBS_BIT_LAST       4'h7

`endif

// ### src/seebs_pkg.sv
// Types of the serial EEPROM bus slave.
// Included constants come from seebs_defines.svh.
`include "seebs_defines.svh"
package seebs_pkg;
  // Size of the capacity variant: how many select bits are address bits
  typedef enum logic [1:0] {
    SEEBS_CAP_1_2K,
    SEEBS_CAP_4K,
    SEEBS_CAP_8K,
    SEEBS_CAP_16K
  } seebs_cap_t;

  // Bus protocol phases
  typedef enum logic [2:0] {
    SEEBS_IDLE,
    SEEBS_SELECT,
    SEEBS_ADDR,
    SEEBS_WDATA,
    SEEBS_RDATA,
    SEEBS_RACK
  } seebs_state_t;
endpackage : seebs_pkg

// ### src/seebs_mem.sv
// Byte memory of the EEPROM array, 2048 x 8, registered read data.
// Assumes one write and one read per clock, same clock as the slave.
`timescale 1ns/1ps
`include "seebs_defines.svh"
module seebs_mem (
  input  wire logic                      clk_i,   // System clock
  input  wire logic                      we_i,    // Write strobe
  input  wire logic [`SEEBS_ADDR_W-1:0]  waddr_i, // Write address
  input  wire logic [7:0]                wdata_i, // Write data
  input  wire logic [`SEEBS_ADDR_W-1:0]  raddr_i, // Read address
  output logic      [7:0]                rdata_o  // Registered read data
);
  logic [7:0] mem_reg [0:(1<<`SEEBS_ADDR_W)-1];

  // Array write; contents survive reset like real cells
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  // Read port always follows the address one clock later
  always_ff @(posedge clk_i) begin
    rdata_o <= mem_reg[raddr_i];
  end
endmodule : seebs_mem

// ### src/seebs_slave.sv
// Two-wire bus slave front end of a serial EEPROM with 16-byte rows.
// Assumes scl/sda and strap pins are asynchronous; all are resynchronised.
//
// Contract
// - Memory access only when select upper nibble equals 1010b.
// - Respond only if chip-enable bits match the three chip-enable pins.
// - Larger parts use those select bits as address bits 8, 9, 10.
// - Eighth select bit: one means read, zero means write.
// - On match, drive acknowledge low in ninth bit time.
// - On mismatch, release bus, no acknowledge, standby until next START.
// - Write: acknowledge select, take and acknowledge address, then await data.
// - Write-protect high from START to address end blocks write, data acks.
// - Byte write: one data byte, acked unless protected, then STOP.
// - Page write takes up to sixteen bytes within one row.
// - Each written byte increments only the four low address bits.
// - Overlong pages wrap inside the row, overwriting earlier bytes.
// - Protected page write: NoAck every data byte, memory unchanged.
// - Programming starts only on STOP right after a write acknowledge.
// - STOP anywhere else starts no programming cycle.
// - While programming, ignore data line and answer no request.
// - Polling select gets NoAck while busy, Ack once done.
// - Reads behave the same whatever the write-protect level.
// - Random read: dummy write, repeated START, select with read bit.
// - Random read: ack, send byte; master NoAcks and sends STOP.
// - START is sda falling with scl high; STOP sda rising with scl high.
// - Protected writes still acknowledge select and address bytes.
// - Sample sda on each rising scl while receiving.
// - Read NoAck from master releases data and returns to standby.
`timescale 1ns/1ps
`include "seebs_defines.svh"
module seebs_slave
  import seebs_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `SEEBS_WRITE_CYCLES // Programming time in clocks
) (
  input  wire logic       clk_i,               // 100 MHz system clock
  input  wire logic       reset_i,             // Synchronous reset, active high
  input  wire seebs_pkg::seebs_cap_t cap_i,    // Capacity variant strap
  input  wire logic       scl_i,               // Bus clock pin
  input  wire logic       sda_i,               // Bus data pin, input side
  output logic            sda_o,               // Bus data output level
  output logic            sda_oe_n_o,          // Low while pulling sda
  input  wire logic       write_protect_input, // High inhibits writes
  input  wire logic       chip_sel_pin_lo,     // Chip enable, select bit 1
  input  wire logic       chip_sel_pin_mid,    // Chip enable, select bit 2
  input  wire logic       chip_sel_pin_hi,     // Chip enable, select bit 3
  output logic            busy_o               // Programming cycle running
);
  import seebs_pkg::*;

  localparam int unsigned PAGE = 1 << `SEEBS_ROW_BITS;

  // Two-stage synchronisers; stage one feeds stage two only.
  // The capacity strap goes through them too, so a strap that settles late
  // can never split one select decode between two capacities.
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;
  always_ff @(posedge clk_i) begin
    sync1_reg <= {cap_i, scl_i, sda_i, write_protect_input,
                  chip_sel_pin_hi, chip_sel_pin_mid, chip_sel_pin_lo};
    sync2_reg <= sync1_reg;
    scl_d_reg <= sync2_reg[5];
    sda_d_reg <= sync2_reg[4];
  end

  logic       scl_s;
  logic       sda_s;
  logic       wp_s;
  logic [2:0] ce_s;
  seebs_cap_t cap_s;
  assign cap_s = seebs_cap_t'(sync2_reg[7:6]);
  assign scl_s = sync2_reg[5];
  assign sda_s = sync2_reg[4];
  assign wp_s  = sync2_reg[3];
  assign ce_s  = sync2_reg[2:0];

  // Bus events derived from the synchronised lines. Each edge is seen two to
  // three clocks after the pin moves, and START/STOP compare the same delayed
  // copies, so scl and sda must each hold a level for several clocks.
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // Protocol state
  seebs_state_t               state_reg;
  logic [3:0]                 bit_reg;
  logic [7:0]                 shift_reg;
  logic [`SEEBS_ADDR_W-1:0]   addr_reg;
  logic [2:0]                 hi_reg;
  logic                       wp_seen_reg;
  logic                       ack_reg;
  logic                       arm_reg;
  logic [7:0]                 page_reg [0:PAGE-1];
  logic [PAGE-1:0]            dirty_reg;
  logic [`SEEBS_ADDR_W-1:0]   row_reg;
  logic                       busy_reg;
  logic [31:0]                timer_reg;
  logic [`SEEBS_ROW_BITS-1:0] prog_idx_reg;
  logic [7:0]                 rd_byte;
  logic                       prog_start;
  logic                       prog_done;

  // Address bits of the select byte by capacity; the rest are chip enables
  logic [2:0] addr_mask;
  always_comb begin
    addr_mask = 3'h0;                     // Unknown strap in the first clocks
    case (cap_s)
      SEEBS_CAP_1_2K: addr_mask = 3'h0;
      SEEBS_CAP_4K:   addr_mask = 3'h1;
      SEEBS_CAP_8K:   addr_mask = 3'h3;
      SEEBS_CAP_16K:  addr_mask = 3'h7;
    endcase
  end

  // Select byte check on the byte just shifted in, bit 0 arriving now
  logic [7:0] sel_byte;
  logic       sel_match;
  assign sel_byte  = {shift_reg[6:0], sda_s};
  assign sel_match = (sel_byte[`SEEBS_TYPE_MSB:`SEEBS_TYPE_LSB] == `SEEBS_TYPE_ID)
                   & (((sel_byte[3:1] ^ ce_s) & ~addr_mask) == 3'h0);

  // Protection latch: any high level from START to address end counts
  always_ff @(posedge clk_i) begin
    if (reset_i || (start_ev && !busy_reg)) begin
      wp_seen_reg <= 1'b0;
    end else if (wp_s && (state_reg == SEEBS_SELECT || state_reg == SEEBS_ADDR)) begin
      wp_seen_reg <= 1'b1;
    end
  end

  // Byte framing and phase machine, driven on bus clock edges
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= SEEBS_IDLE;
      bit_reg   <= 4'h0;
      shift_reg <= 8'h00;
      ack_reg   <= 1'b0;
      arm_reg   <= 1'b0;
      hi_reg    <= 3'h0;
      addr_reg  <= '0;
    end else if (busy_reg) begin
      state_reg <= SEEBS_IDLE;
      ack_reg   <= 1'b0;
      arm_reg   <= 1'b0;
    end else if (start_ev) begin
      state_reg <= SEEBS_SELECT;
      bit_reg   <= 4'h0;
      ack_reg   <= 1'b0;
      arm_reg   <= 1'b0;
    end else if (stop_ev) begin
      state_reg <= SEEBS_IDLE;
      ack_reg   <= 1'b0;
      arm_reg   <= 1'b0;
    end else if (scl_rise && state_reg != SEEBS_IDLE) begin
      // Ack slot sampled on rise; only read phase cares about master ack
      if (bit_reg == `SEEBS_BIT_ACK) begin
        bit_reg <= 4'h0;
        if (state_reg == SEEBS_RACK) begin
          if (sda_s) begin
            state_reg <= SEEBS_IDLE;
          end else begin
            state_reg <= SEEBS_RDATA;
          end
        end
      end else begin
        shift_reg <= sel_byte;
        bit_reg   <= bit_reg + 4'h1;
        // The scl rise of the tenth slot keeps the arm, so a STOP there counts
        if (bit_reg != 4'h0) begin
          arm_reg <= 1'b0;
        end
        if (bit_reg == `SEEBS_BIT_LAST) begin
          unique case (state_reg)
            SEEBS_SELECT: begin
              if (!sel_match) begin
                state_reg <= SEEBS_IDLE;
              end else begin
                ack_reg <= 1'b1;
                hi_reg  <= sel_byte[3:1] & addr_mask;
                if (sel_byte[`SEEBS_RW_BIT]) begin
                  state_reg <= SEEBS_RDATA;
                end else begin
                  state_reg <= SEEBS_ADDR;
                end
              end
            end
            SEEBS_ADDR: begin
              ack_reg   <= 1'b1;
              addr_reg  <= {hi_reg, sel_byte};
              state_reg <= SEEBS_WDATA;
            end
            SEEBS_WDATA: begin
              ack_reg  <= ~wp_seen_reg;
              arm_reg  <= ~wp_seen_reg;
              addr_reg <= {addr_reg[`SEEBS_ADDR_W-1:`SEEBS_ROW_BITS],
                           addr_reg[`SEEBS_ROW_BITS-1:0] + 4'h1};
            end
            SEEBS_RDATA: begin
              state_reg <= SEEBS_RACK;
              addr_reg  <= addr_reg + 11'h001;
            end
            default: begin
              state_reg <= SEEBS_IDLE;
            end
          endcase
        end
      end
    end else if (scl_fall && bit_reg == 4'h0) begin
      ack_reg <= 1'b0;                    // Release after the ack clock pulse
    end
  end

  // Page latches: data held until STOP, so a wrapped row overwrites older bytes.
  // A byte is latched before its ack is known; only the armed STOP commits it,
  // and a later START outside SEEBS_WDATA clears the leftovers of a frame that was cut.
  always_ff @(posedge clk_i) begin
    if (reset_i || (start_ev && !busy_reg && state_reg != SEEBS_WDATA)) begin
      dirty_reg <= '0;
    end else if (prog_done) begin
      dirty_reg <= '0;
    end else if (!busy_reg && scl_rise && state_reg == SEEBS_WDATA
                 && bit_reg == `SEEBS_BIT_LAST && !wp_seen_reg) begin
      page_reg[addr_reg[`SEEBS_ROW_BITS-1:0]]  <= sel_byte;
      dirty_reg[addr_reg[`SEEBS_ROW_BITS-1:0]] <= 1'b1;
      row_reg <= addr_reg;
    end
  end

  // Programming cycle: start on STOP in the slot after a write ack.
  // The timer runs the full programming time even for a single byte; a
  // master that polls sees the same busy span whatever it wrote.
  assign prog_start = stop_ev && arm_reg && !busy_reg && (dirty_reg != '0);
  assign prog_done  = busy_reg && (timer_reg >= WRITE_CYCLES - 1);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      busy_reg  <= 1'b0;
      timer_reg <= 32'h00000000;
    end else if (prog_start) begin
      busy_reg  <= 1'b1;
      timer_reg <= 32'h00000000;
    end else if (prog_done) begin
      busy_reg  <= 1'b0;
    end else if (busy_reg) begin
      timer_reg <= timer_reg + 32'h00000001;
    end
  end

  // Copy latched bytes into the array, one per clock, during busy
  always_ff @(posedge clk_i) begin
    if (reset_i || prog_start) begin
      prog_idx_reg <= '0;
    end else if (busy_reg) begin
      prog_idx_reg <= prog_idx_reg + 4'h1;
    end
  end

  logic mem_we;
  assign mem_we = busy_reg && dirty_reg[prog_idx_reg] && (timer_reg < PAGE);

  seebs_mem u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i ({row_reg[`SEEBS_ADDR_W-1:`SEEBS_ROW_BITS], prog_idx_reg}),
    .wdata_i (page_reg[prog_idx_reg]),
    .raddr_i (addr_reg),
    .rdata_o (rd_byte)
  );

  // Ack drive window: from the scl fall after the eighth bit to the fall that
  // ends the ninth. Pulling on the eighth rise instead would drop sda while
  // scl is high, which every listener, this slave too, takes for a START.
  logic ack_drv_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i || busy_reg || start_ev || stop_ev) begin
      ack_drv_reg <= 1'b0;
    end else if (scl_fall && bit_reg == `SEEBS_BIT_ACK) begin
      ack_drv_reg <= ack_reg;
    end else if (scl_fall && bit_reg == 4'h0) begin
      ack_drv_reg <= 1'b0;
    end
  end

  // Read shifter: every bit goes out after an scl fall, so sda only moves
  // while scl is low; the last bit stands until the fall after its rise
  logic [7:0] tx_reg;
  logic       rd_drv_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i || busy_reg || start_ev || stop_ev) begin
      tx_reg     <= 8'hFF;
      rd_drv_reg <= 1'b0;
    end else if (scl_fall && state_reg == SEEBS_RDATA && bit_reg == 4'h0) begin
      tx_reg     <= rd_byte;
      rd_drv_reg <= 1'b1;
    end else if (scl_fall && bit_reg == `SEEBS_BIT_ACK) begin
      rd_drv_reg <= 1'b0;                 // Master owns the ack slot
    end else if (scl_fall && state_reg == SEEBS_RDATA) begin
      tx_reg <= {tx_reg[6:0], 1'b1};
    end
  end

  // Pin driver: pull low for ack or a zero read bit, else release.
  // Both sources change on the same clock, so the pin never glitches high
  // between an ack and a leading zero data bit.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sda_o      <= 1'b1;
      sda_oe_n_o <= 1'b1;
    end else begin
      sda_o      <= 1'b0;
      sda_oe_n_o <= ~(ack_drv_reg || (rd_drv_reg && !tx_reg[7]));
    end
  end

  // Busy flag to the pins for observation
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= busy_reg;
    end
  end
endmodule : seebs_slave

// ### test/seebs_slave_sva.sv
// Assertion checker of the EEPROM bus slave, bound to its ports.
// Assumes one master that holds sda steady while scl is high.
`timescale 1ns/1ps
module seebs_slave_sva
  import seebs_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = 40 // Programming time in clocks
) (
  input wire logic       clk_i,               // System clock
  input wire logic       reset_i,             // Synchronous reset
  input wire seebs_cap_t cap_i,               // Capacity strap
  input wire logic       scl_i,               // Bus clock
  input wire logic       sda_i,               // Wire level of sda
  input wire logic       sda_o,               // Data output level
  input wire logic       sda_oe_n_o,          // Low while pulling
  input wire logic       write_protect_input, // Write inhibit
  input wire logic       chip_sel_pin_lo,     // Chip enable, bit 1
  input wire logic       chip_sel_pin_mid,    // Chip enable, bit 2
  input wire logic       chip_sel_pin_hi,     // Chip enable, bit 3
  input wire logic       busy_o               // Programming busy
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic        scl_q, sda_q, wp_lat, wr_dir, bsy_fr;
  logic [3:0]  bit_cnt, byte_idx;
  logic [7:0]  sh_reg;
  int unsigned busy_cnt, since_stop;
  // Raw bus events; the design sees them a few clocks later
  wire start_ev = scl_i & scl_q & sda_q & ~sda_i;
  wire stop_ev  = scl_i & scl_q & ~sda_q & sda_i;
  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire sel_slot = (bit_cnt == 4'h8) && (byte_idx == 4'h0);
  wire type_ok  = sh_reg[7:4] == 4'hA;
  wire ce_ok    = (sh_reg[3] == chip_sel_pin_hi || cap_i == SEEBS_CAP_16K) &&
                  (sh_reg[2] == chip_sel_pin_mid || cap_i >= SEEBS_CAP_8K) &&
                  (sh_reg[1] == chip_sel_pin_lo || cap_i != SEEBS_CAP_1_2K);
  // Edge history and busy timing
  always_ff @(posedge clk_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    busy_cnt <= (reset_i || !busy_o) ? 0 : busy_cnt + 1;
    since_stop <= (reset_i || stop_ev) ? 0 : since_stop + 1;
  end
  // Frame position; protection counts from START to the address byte end
  always_ff @(posedge clk_i) begin
    if (reset_i || start_ev) begin
      bit_cnt <= 4'h0;
      byte_idx <= 4'h0;
      wp_lat <= write_protect_input;
      bsy_fr <= busy_o;
    end else begin
      if (scl_rise) bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      if (scl_rise && bit_cnt < 4'h8) sh_reg <= {sh_reg[6:0], sda_i};
      if (scl_rise && sel_slot) wr_dir <= ~sh_reg[0];
      if (scl_rise && bit_cnt == 4'h8 && byte_idx != 4'hF) byte_idx <= byte_idx + 4'h1;
      if (byte_idx < 4'h2 && write_protect_input) wp_lat <= 1'b1;
      if (busy_o) bsy_fr <= 1'b1;
    end
  end
  a_type_match: assert property ($fell(sda_oe_n_o) && sel_slot |-> type_ok)
    else $error("Select acknowledged with a foreign type code");
  a_chip_match: assert property ($fell(sda_oe_n_o) && sel_slot |-> ce_ok)
    else $error("Select acknowledged with other chip enables");
  a_sel_ack: assert property (scl_fall && sel_slot && type_ok && ce_ok && !bsy_fr
    |-> ##[1:8] !sda_oe_n_o) else $error("Matching select not acknowledged");
  a_pull_low: assert property (!sda_oe_n_o |-> !sda_o)
    else $error("Driven data level is not low");
  a_sda_scl_high: assert property (scl_i && scl_q |-> $stable(sda_oe_n_o))
    else $error("Slave moved sda while scl was high");
  a_busy_silent: assert property (busy_o |-> sda_oe_n_o)
    else $error("Bus driven while programming");
  a_busy_span: assert property ($fell(busy_o) |-> busy_cnt == WRITE_CYCLES)
    else $error("Programming time differs from its setting");
  a_prog_on_stop: assert property ($rose(busy_o) |-> since_stop <= 10)
    else $error("Programming started without a STOP");
  a_addr_ack: assert property (scl_fall && bit_cnt == 4'h8 && byte_idx == 4'h1 && wr_dir
    && !bsy_fr |-> ##[1:8] !sda_oe_n_o) else $error("Address byte not acknowledged");
  a_wp_nack: assert property (scl_fall && bit_cnt == 4'h8 && byte_idx >= 4'h2 && wr_dir
    && wp_lat |-> sda_oe_n_o [*8]) else $error("Protected data byte acknowledged");
  c_prog: cover property ($rose(busy_o));
  c_wp_data: cover property (scl_fall && bit_cnt == 4'h8 && byte_idx >= 4'h2 && wp_lat);
  c_sel_refused: cover property (scl_fall && sel_slot && !(type_ok && ce_ok));
endmodule : seebs_slave_sva

bind seebs_slave seebs_slave_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_seebs_slave_sva (
  .clk_i(clk_i), .reset_i(reset_i), .cap_i(cap_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .write_protect_input(write_protect_input),
  .chip_sel_pin_lo(chip_sel_pin_lo), .chip_sel_pin_mid(chip_sel_pin_mid),
  .chip_sel_pin_hi(chip_sel_pin_hi), .busy_o(busy_o));

// ### test/seebs_master.sv
// Bus master model: start, stop and byte transfers on the two-wire bus.
// Assumes one caller at a time and a pull-up on sda.
`timescale 1ns/1ps
module seebs_master (
  input  wire logic clk_i, // System clock
  input  wire logic sda_i, // Wire level of sda
  output logic      scl_o, // Bus clock, still between frames
  output logic      sda_o  // Data drive, high releases
);
  localparam int HALF = 10; // Half bit, well above the sync latency
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Set both lines, then hold them for n falling edges
  task automatic put(input logic c, input logic d, input int n);
    scl_o = c;
    sda_o = d;
    repeat (n) @(negedge clk_i);
  endtask : put
  // Data moves only with scl low, else a START or STOP is seen
  task automatic cycle(input logic a, input logic b, input logic c);
    put(1'b0, sda_o, 3);
    put(1'b0, a, HALF);
    put(1'b1, b, HALF);
    put(1'b1, c, HALF);
  endtask : cycle
  task automatic start_cond();
    cycle(1'b1, 1'b1, 1'b0);
  endtask : start_cond
  task automatic stop_cond();
    cycle(1'b0, 1'b0, 1'b1);
  endtask : stop_cond
  // Byte out MSB first, then the acknowledge slot
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      cycle(b[i], b[i], b[i]);
    end
    cycle(1'b1, 1'b1, 1'b1);
    ack = ~sda_i;
  endtask : send_byte
  // Byte in, then our acknowledge or release
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      cycle(1'b1, 1'b1, 1'b1);
      d[i] = sda_i;
    end
    cycle(~ack, ~ack, ~ack);
  endtask : recv_byte
endmodule : seebs_master

// ### test/seebs_slave_bench.sv
// Self-checking bench of the EEPROM bus slave: writes, polling, reads.
// Assumes a 4K strap, a pull-up on sda and a short programming time.
`timescale 1ns/1ps
module seebs_slave_bench;
  import seebs_pkg::*;
  localparam int unsigned WCYC = 2000; // Long enough to see polls refused
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        wp = 1'b0;
  logic        ce_lo = 1'b1, ce_mid = 1'b1, ce_hi = 1'b0;
  seebs_cap_t  cap = SEEBS_CAP_4K;
  logic        scl, sda_m, sda_o, sda_oe_n, busy, sda;
  logic [7:0]  bad [3];
  logic [31:0] lfsr_q = 32'h8F7F6D38;
  logic [7:0]  exp_mem [int];
  int          err_total = 0;
  int          checked = 0;
  always #5 clk_i = ~clk_i; // 100 MHz
  assign sda = sda_m & (sda_oe_n | sda_o); // Open drain with pull-up
  seebs_slave #(.WRITE_CYCLES(WCYC)) u_seebs_slave (.clk_i(clk_i), .reset_i(reset_i),
    .cap_i(cap), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
    .write_protect_input(wp), .chip_sel_pin_lo(ce_lo), .chip_sel_pin_mid(ce_mid),
    .chip_sel_pin_hi(ce_hi), .busy_o(busy));
  seebs_master u_seebs_master (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
  // Expected-value helpers
  function automatic logic [7:0] sel_byte(input logic [10:0] a, input logic rd);
    return {4'hA, ce_hi, ce_mid, a[8], rd};
  endfunction : sel_byte
  function automatic logic [10:0] page_addr(input logic [10:0] a, input int k);
    return {a[10:4], a[3:0] + 4'(k)};
  endfunction : page_addr
  // Next LFSR word; the fixed seed makes every run repeat
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction : rnd
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  // Busy level after STOP, then polls; refused polls only while busy
  task automatic settle_busy(input logic exp_busy);
    logic ack;
    int   n;
    repeat (12) @(negedge clk_i);
    check({7'h0, busy}, {7'h0, exp_busy});
    ack = 1'b0;
    n = 0;
    while (!ack && n < 40) begin
      u_seebs_master.start_cond();
      u_seebs_master.send_byte(sel_byte(11'h0, 1'b0), ack);
      u_seebs_master.stop_cond();
      n++;
    end
    check({7'h0, n > 1}, {7'h0, exp_busy});
    if (!ack) begin
      err_total++;
      $display("Error at %0t ns: device never answered a poll", $time);
      report_and_stop();
    end
  endtask : settle_busy
  task automatic write_run(input logic [10:0] a, input int cnt, input logic prot);
    logic        ack;
    logic [31:0] r;
    u_seebs_master.start_cond();
    u_seebs_master.send_byte(sel_byte(a, 1'b0), ack);
    check({7'h0, ack}, 8'h01);
    u_seebs_master.send_byte(a[7:0], ack);
    check({7'h0, ack}, 8'h01);
    for (int k = 0; k < cnt; k++) begin
      r = rnd();
      u_seebs_master.send_byte(r[7:0], ack);
      check({7'h0, ack}, {7'h0, ~prot});
      if (!prot) exp_mem[page_addr(a, k)] = r[7:0];
    end
    u_seebs_master.stop_cond();
    settle_busy(~prot);
  endtask : write_run
  task automatic read_check(input logic [10:0] a);
    logic       ack;
    logic [7:0] d;
    u_seebs_master.start_cond();
    u_seebs_master.send_byte(sel_byte(a, 1'b0), ack);
    u_seebs_master.send_byte(a[7:0], ack);
    u_seebs_master.start_cond();
    u_seebs_master.send_byte(sel_byte(a, 1'b1), ack);
    check({7'h0, ack}, 8'h01);
    u_seebs_master.recv_byte(1'b0, d);
    u_seebs_master.stop_cond();
    check(d, exp_mem[a]);
  endtask : read_check
  // Main sequence
  initial begin
    logic [31:0] r;
    logic        ack;
    repeat (6) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge clk_i);
    for (int n = 0; n < 3; n++) begin
      r = rnd() & 32'hFFFFF9FF; // 4K strap: address bits 10 and 9 do not exist
      write_run(r[10:0], 1, 1'b0);
      read_check(r[10:0]);
    end
    $display("Byte writes done");
    // Page starting two bytes before the row end wraps and overwrites
    r = rnd() & 32'hFFFFF9FF; // 4K strap: address bits 10 and 9 do not exist
    write_run({r[10:4], 4'hE}, 18, 1'b0);
    foreach (bad[i]) read_check({r[10:4], 4'hE - 4'(i)});
    read_check({r[10:4], 4'h0});
    $display("Page write done");
    wp = 1'b1;
    write_run({r[10:4], 4'h1}, 2, 1'b1);
    read_check({r[10:4], 4'h1});
    wp = 1'b0;
    $display("Protected write done");
    bad = '{{4'hB, ce_hi, ce_mid, 2'b00}, {4'hA, ~ce_hi, ce_mid, 2'b00}, {4'hA, ce_hi, ~ce_mid, 2'b01}};
    foreach (bad[i]) begin
      u_seebs_master.start_cond();
      u_seebs_master.send_byte(bad[i], ack);
      check({7'h0, ack}, 8'h00);
      u_seebs_master.stop_cond();
    end
    $display("Foreign selects done");
    // STOP in mid byte must not program the latched byte
    u_seebs_master.start_cond();
    u_seebs_master.send_byte(sel_byte({r[10:4], 4'h0}, 1'b0), ack);
    u_seebs_master.send_byte({r[7:4], 4'h0}, ack);
    u_seebs_master.send_byte(~exp_mem[{r[10:4], 4'h0}], ack);
    repeat (3) u_seebs_master.cycle(1'b0, 1'b0, 1'b0);
    u_seebs_master.stop_cond();
    settle_busy(1'b0);
    read_check({r[10:4], 4'h0});
    $display("Aborted write done");
    report_and_stop();
  end
  // Hang guard
  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    $display("Error at %0t ns: run did not finish", $time);
    report_and_stop();
  end
endmodule : seebs_slave_bench
